// ---- pkg/sfp_pkg.sv ----
// Shared constants and types for the serial flash protection front end
package sfp_pkg;
  // Status register bit positions
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned WEL_BIT = 1;
  localparam int unsigned LVL_LO_BIT = 2;
  localparam int unsigned TB_BIT = 5;
  localparam int unsigned RSVD_BIT = 6;
  localparam int unsigned LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  // Writable bits of the status register
  localparam logic [7:0] STATUS_WMASK = 8'hbc;
  // Bits per bus cycle
  localparam int unsigned BUS_CYCLE_BITS = 8;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  // Array geometry: 18 address bits, 64 KiB blocks
  localparam int unsigned ADDR_W = 24;
  localparam logic [23:0] BLOCK1_BASE = 24'h010000;
  localparam logic [23:0] BLOCK2_BASE = 24'h020000;
  localparam logic [23:0] BLOCK3_BASE = 24'h030000;
  localparam logic [23:0] ARRAY_TOP = 24'h03ffff;
  // Opcodes handled by the front end
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;

  typedef enum logic [2:0] {
    SFP_ARRAY_PROGRAM = 3'b001,
    SFP_ARRAY_SECTOR = 3'b010,
    SFP_ARRAY_BLOCK = 3'b011,
    SFP_ARRAY_CHIP = 3'b100
  } sfp_array_op_t;

  // Request handed to the array engine
  typedef struct packed {
    sfp_array_op_t op;
    logic [23:0] addr;
  } sfp_array_req_t;

  // Non-volatile protection fields
  typedef struct packed {
    logic lock;
    logic topBottom;
    logic [2:0] level;
  } sfp_protect_t;
endpackage : sfp_pkg

// ---- src/sfp_front.sv ----
// Serial flash front end: framing, pause, status and array protection
`timescale 1ns/1ps
`default_nettype none

module sfp_front
(
  input wire logic core_clk,
  input wire logic rst_n,
  // Link side, serial clock is its own domain
  input wire logic sck,
  input wire logic chipSel_n,
  input wire logic serIn,
  input wire logic pause_n,
  input wire logic writeProtect_n,
  output logic serOut,
  output logic serOutEn,
  // Non-volatile image of the protection fields
  input wire sfp_pkg::sfp_protect_t nvLoad,
  output sfp_pkg::sfp_protect_t nvStore,
  // Array engine, core domain
  input wire logic arrayBusy,
  output logic arrayReqValid,
  output sfp_pkg::sfp_array_req_t arrayReq,
  output logic [7:0] statusOut
);

  // Link domain state
  logic [2:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] opcode_ff;
  logic [1:0] byteCnt_ff;
  logic [23:0] addr_ff;
  logic [7:0] wrData_ff;
  logic haveData_ff;
  logic outActive_ff;
  logic [7:0] outShift_ff;
  logic paused_ff;
  logic frameTgl_ff;
  logic [7:0] frameOp_ff;
  logic [23:0] frameAddr_ff;
  logic [7:0] frameData_ff;
  logic frameData_v_ff;
  // Core domain state
  logic weLatch_ff;
  sfp_pkg::sfp_protect_t prot_ff;
  logic loaded_ff;
  logic tglSeen_ff;
  logic reqValid_ff;
  sfp_pkg::sfp_array_req_t req_ff;

  logic frameTglSync;
  logic wpSync;
  logic busySync;
  logic linkRst_n;
  logic pausedNow;
  logic [7:0] nextShift;
  logic byteDone;

  // Protected-address check; used for program, sector and block erase only
  function automatic logic isProtected(input sfp_pkg::sfp_protect_t p,
                                       input logic [23:0] a);
    logic [23:0] lim;
    lim = 24'h000000;
    if (p.level[1:0] == 2'b11)
      return 1'b1;
    case (p.level)
      3'b001: lim = p.topBottom ? sfp_pkg::BLOCK1_BASE : sfp_pkg::BLOCK3_BASE;
      3'b010: lim = sfp_pkg::BLOCK2_BASE;
      3'b110: lim = p.topBottom ? sfp_pkg::BLOCK3_BASE : sfp_pkg::BLOCK1_BASE;
      default: return 1'b0;
    endcase
    // Bottom select protects below the limit, top at and above it
    if (p.topBottom)
      return a < lim;
    return (a >= lim) && (a <= sfp_pkg::ARRAY_TOP);
  endfunction : isProtected

  // Status write permission from pin and lock
  function automatic logic statusWriteOk(input logic wp, input logic lock);
    return wp || !lock;
  endfunction : statusWriteOk

  // Link logic reset: device reset or select high (also ends pause)
  assign linkRst_n = rst_n && !chipSel_n;

  // Pause state frozen at each rising clock; it cannot move while clock is high
  always_ff @(posedge sck or negedge linkRst_n)
  begin
    if (!linkRst_n)
      paused_ff <= 1'b0;
    else
      paused_ff <= !pause_n;
  end

  // Clock low: pause follows the pin at once, so entry and exit need no extra edge
  assign pausedNow = sck ? paused_ff : !pause_n;

  assign nextShift = {shift_ff[6:0], serIn};
  assign byteDone = (bitCnt_ff == sfp_pkg::LAST_BIT_IDX);

  // Input shifter, MSB first on rising clock, frozen while paused
  always_ff @(posedge sck or negedge linkRst_n)
  begin
    if (!linkRst_n)
    begin
      bitCnt_ff <= 3'h0;
      shift_ff <= 8'h00;
    end
    else if (pause_n) // Pin level at the rise is the pause state
    begin
      shift_ff <= nextShift;
      bitCnt_ff <= bitCnt_ff + 3'h1;
    end
  end

  // Byte assembly: opcode, three address bytes, first data byte
  always_ff @(posedge sck or negedge linkRst_n)
  begin
    if (!linkRst_n)
    begin
      opcode_ff <= 8'h00;
      byteCnt_ff <= 2'h0;
      addr_ff <= 24'h000000;
      wrData_ff <= 8'h00;
      haveData_ff <= 1'b0;
    end
    else if (pause_n && byteDone)
    begin
      if (byteCnt_ff == 2'h0 && opcode_ff == 8'h00 && !haveData_ff)
        opcode_ff <= nextShift;
      else if (opcode_ff == sfp_pkg::OP_WRITE_STATUS && !haveData_ff)
      begin
        wrData_ff <= nextShift;
        haveData_ff <= 1'b1;
      end
      else if (byteCnt_ff != 2'h3)
      begin
        addr_ff <= {addr_ff[15:0], nextShift};
        byteCnt_ff <= byteCnt_ff + 2'h1;
      end
      else
        haveData_ff <= 1'b1; // program data byte seen
    end
  end

  // Status read: output shifts on falling clock
  always_ff @(negedge sck or negedge linkRst_n)
  begin
    if (!linkRst_n)
    begin
      outActive_ff <= 1'b0;
      outShift_ff <= 8'h00;
    end
    else if (pause_n && opcode_ff == sfp_pkg::OP_READ_STATUS)
    begin
      outActive_ff <= 1'b1;
      // Statusout is slow-changing; sampled at each byte start
      outShift_ff <= (bitCnt_ff == 3'h0) ? statusOut : {outShift_ff[6:0], 1'b0};
    end
  end

  assign serOut = outShift_ff[7];
  assign serOutEn = outActive_ff && !pausedNow;

  // Frame capture on select rise; a frame that ends mid-byte is dropped whole
  always_ff @(posedge chipSel_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameTgl_ff <= 1'b0;
      frameOp_ff <= 8'h00;
      frameAddr_ff <= 24'h000000;
      frameData_ff <= 8'h00;
      frameData_v_ff <= 1'b0;
    end
    else if (bitCnt_ff == 3'h0 && opcode_ff != 8'h00)
    begin
      frameTgl_ff <= !frameTgl_ff;
      frameOp_ff <= opcode_ff;
      frameAddr_ff <= addr_ff;
      frameData_ff <= wrData_ff;
      frameData_v_ff <= haveData_ff;
    end
  end

  // Crossings into the core clock
  sfp_sync uTglSync (.clk(core_clk), .rst_n(rst_n), .asyncIn(frameTgl_ff),
    .syncOut(frameTglSync));
  sfp_sync uWpSync (.clk(core_clk), .rst_n(rst_n), .asyncIn(writeProtect_n),
    .syncOut(wpSync));
  sfp_sync uBusySync (.clk(core_clk), .rst_n(rst_n), .asyncIn(arrayBusy),
    .syncOut(busySync));

  // Core: fields restored from storage after reset release
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loaded_ff <= 1'b0;
      tglSeen_ff <= 1'b0;
      weLatch_ff <= 1'b0;
      prot_ff <= '{lock: 1'b0, topBottom: 1'b0, level: sfp_pkg::LEVEL_RESET};
      reqValid_ff <= 1'b0;
      req_ff <= '{op: sfp_pkg::SFP_ARRAY_PROGRAM, addr: 24'h000000};
    end
    else if (!loaded_ff)
    begin
      loaded_ff <= 1'b1;
      prot_ff <= nvLoad;
      tglSeen_ff <= frameTglSync;
    end
    else
    begin
      reqValid_ff <= 1'b0;
      if (frameTglSync != tglSeen_ff)
      begin
        tglSeen_ff <= frameTglSync;
        case (frameOp_ff)
          sfp_pkg::OP_WRITE_ENABLE: weLatch_ff <= 1'b1;
          sfp_pkg::OP_WRITE_DISABLE: weLatch_ff <= 1'b0;
          sfp_pkg::OP_WRITE_STATUS:
          begin
            // Locked writes leave the protection bits alone; write enable still clears
            if (weLatch_ff && frameData_v_ff && statusWriteOk(wpSync, prot_ff.lock))
            begin
              prot_ff.level <= frameData_ff[sfp_pkg::LVL_LO_BIT +: 3];
              prot_ff.topBottom <= frameData_ff[sfp_pkg::TB_BIT];
              prot_ff.lock <= frameData_ff[sfp_pkg::LOCK_BIT];
            end
            weLatch_ff <= 1'b0;
          end
          sfp_pkg::OP_CHIP_ERASE_A, sfp_pkg::OP_CHIP_ERASE_B:
          begin
            if (weLatch_ff && !busySync && prot_ff.level == 3'h0)
            begin
              reqValid_ff <= 1'b1;
              req_ff <= '{op: sfp_pkg::SFP_ARRAY_CHIP, addr: 24'h000000};
            end
            weLatch_ff <= 1'b0;
          end
          sfp_pkg::OP_PROGRAM, sfp_pkg::OP_SECTOR_ERASE, sfp_pkg::OP_BLOCK_ERASE:
          begin
            if (weLatch_ff && !busySync && !isProtected(prot_ff, frameAddr_ff))
            begin
              reqValid_ff <= 1'b1;
              req_ff.addr <= frameAddr_ff;
              req_ff.op <= (frameOp_ff == sfp_pkg::OP_PROGRAM) ? sfp_pkg::SFP_ARRAY_PROGRAM :
                (frameOp_ff == sfp_pkg::OP_SECTOR_ERASE) ? sfp_pkg::SFP_ARRAY_SECTOR :
                sfp_pkg::SFP_ARRAY_BLOCK;
            end
            weLatch_ff <= 1'b0;
          end
          default: weLatch_ff <= weLatch_ff;
        endcase
      end
    end
  end

  assign arrayReqValid = reqValid_ff;
  assign arrayReq = req_ff;
  assign nvStore = prot_ff;

  // Status layout, reserved bit reads zero
  assign statusOut = {prot_ff.lock, 1'b0, prot_ff.topBottom, prot_ff.level,
    weLatch_ff, busySync};
endmodule : sfp_front
`default_nettype wire

// ---- src/sfp_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sfp_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_ff;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end
endmodule : sfp_sync
`default_nettype wire

// ---- tb/sfp_front_sva.sv ----
// Port assertions for the protection front end
`timescale 1ns/1ps
`default_nettype none
module sfp_front_sva
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic chipSel_n,
  input wire logic pause_n,
  input wire logic writeProtect_n,
  input wire logic serOutEn,
  input wire sfp_pkg::sfp_protect_t nvStore,
  input wire logic arrayReqValid,
  input wire sfp_pkg::sfp_array_req_t arrayReq,
  input wire logic [7:0] statusOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Protected-region decode, written apart from the design's own
  function automatic logic hit(input logic t, input logic [2:0] l, input logic [23:0] a);
    if (l[1:0] == 2'h3) return 1'b1;
    if (l == 3'h1) return t ? a[17:16] == 2'h0 : a[17:16] == 2'h3;
    if (l == 3'h2) return t ? a[17:16] <= 2'h1 : a[17:16] >= 2'h2;
    if (l == 3'h6) return t ? a[17:16] <= 2'h2 : a[17:16] >= 2'h1;
    return 1'b0;
  endfunction : hit
  // Lock in force long enough to pass the pin synchroniser
  sequence s_locked;
    (!writeProtect_n && nvStore.lock)[*4];
  endsequence
  property p_pulse; arrayReqValid |=> !arrayReqValid; endproperty
  property p_chip; arrayReqValid && arrayReq.op == sfp_pkg::SFP_ARRAY_CHIP
    |-> nvStore.level == 3'h0; endproperty
  property p_prot; arrayReqValid && arrayReq.op != sfp_pkg::SFP_ARRAY_CHIP
    |-> !hit(nvStore.topBottom, nvStore.level, arrayReq.addr); endproperty
  property p_map; statusOut[7:2] == {nvStore.lock, 1'b0, nvStore.topBottom, nvStore.level};
  endproperty
  property p_locked; s_locked |=> $stable(nvStore); endproperty
  property p_frame; $changed(nvStore) |-> $past(chipSel_n, 2); endproperty
  property p_idle; chipSel_n [*3] |-> !serOutEn; endproperty
  property p_pause; @(negedge sck) disable iff (!rst_n || chipSel_n)
    !pause_n |=> !serOutEn; endproperty
  a_pulse: assert property (p_pulse)
    else $error("request pulse longer than one cycle");
  a_chip: assert property (p_chip)
    else $error("chip erase passed with nonzero level");
  a_prot: assert property (p_prot)
    else $error("request inside protected region");
  a_map: assert property (p_map)
    else $error("status byte layout wrong");
  a_locked: assert property (p_locked)
    else $error("fields changed while locked");
  a_frame: assert property (p_frame)
    else $error("fields changed inside a frame");
  a_idle: assert property (p_idle)
    else $error("output driven while deselected");
  a_pause: assert property (p_pause)
    else $error("output driven while paused");
endmodule : sfp_front_sva
`default_nettype wire

// ---- tb/sfp_host.sv ----
// Host serial controller model, clock idles low
`timescale 1ns/1ps
`default_nettype none
module sfp_host
(
  output logic sck,
  output logic chipSel_n,
  output logic serIn,
  output logic pause_n
);
  initial
  begin
    sck = 1'b0;
    chipSel_n = 1'b1;
    serIn = 1'b0;
    pause_n = 1'b1;
  end
  // MSB first, 15 ns link period
  task automatic shift(input logic [31:0] d, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serIn = d[i];
      #7.5 sck = 1'b1;
      #7.5 sck = 1'b0;
    end
  endtask : shift
  // Released data line shows the inverse, not a stale value
  task automatic frame(input logic [31:0] d, input int n);
    #3 chipSel_n = 1'b0;
    #7.5 shift(d, n);
    #4 chipSel_n = 1'b1;
    serIn = ~serIn;
  endtask : frame
endmodule : sfp_host
`default_nettype wire

// ---- tb/tb_serial_flash_write_protect_hold.sv ----
// Self-checking bench for the protection front end
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_write_protect_hold;
  int errors;
  int checks;
  logic core_clk, rst_n, writeProtect_n, sck, chipSel_n, serIn, pause_n;
  logic serOut, serOutEn, arrayReqValid, gotV;
  sfp_pkg::sfp_protect_t nvStore;
  sfp_pkg::sfp_array_req_t arrayReq, gotR;
  logic [7:0] statusOut;
  sfp_host host (.sck(sck), .chipSel_n(chipSel_n), .serIn(serIn), .pause_n(pause_n));
  sfp_front dut (.core_clk(core_clk), .rst_n(rst_n), .sck(sck), .chipSel_n(chipSel_n),
    .serIn(serIn), .pause_n(pause_n), .writeProtect_n(writeProtect_n), .serOut(serOut),
    .serOutEn(serOutEn), .nvLoad(5'h00), .nvStore(nvStore), .arrayBusy(1'b0),
    .arrayReqValid(arrayReqValid), .arrayReq(arrayReq), .statusOut(statusOut));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic cmp(input string w, input logic [26:0] e, input logic [26:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : cmp
  task automatic report_and_stop;
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // One frame, then a fixed window longer than the answer latency
  task automatic op(input logic [31:0] d, input int n);
    gotV = 1'b0;
    host.frame(d, n);
    repeat (8)
    begin
      @(posedge core_clk);
      #1;
      if (arrayReqValid === 1'b1)
      begin
        gotV = 1'b1;
        gotR = arrayReq;
      end
    end
  endtask : op
  task automatic wsr(input logic [7:0] v);
    op(32'h06, 8);
    op({8'h01, v}, 16);
  endtask : wsr
  task automatic setwp(input logic v);
    @(posedge core_clk);
    #1 writeProtect_n = v;
    repeat (6) @(posedge core_clk);
  endtask : setwp
  task automatic s_status;
    cmp("reset", 8'h00, statusOut);
    op(32'h06, 8);
    cmp("wel", 8'h02, statusOut);
    wsr(8'hff);
    cmp("wmask", 8'hbc, statusOut);
    wsr(8'h00);
    cmp("pinhigh", 8'h00, statusOut);
    wsr(8'h84);
    setwp(1'b0);
    wsr(8'h20);
    cmp("locked", 8'h84, statusOut);
    setwp(1'b1);
    wsr(8'h00);
    cmp("unlock", 8'h00, statusOut);
  endtask : s_status
  // Entry: status, opcode, address, accepted
  task automatic s_protect;
    logic [40:0] t [14] = '{{8'h04, 8'h02, 24'h03ffff, 1'b0}, {8'h04, 8'h02, 24'h02ffff, 1'b1},
      {8'h08, 8'h20, 24'h020000, 1'b0}, {8'h08, 8'h20, 24'h01ffff, 1'b1},
      {8'h18, 8'hd8, 24'h010000, 1'b0}, {8'h18, 8'hd8, 24'h00ffff, 1'b1},
      {8'h24, 8'h02, 24'h00ffff, 1'b0}, {8'h24, 8'h02, 24'h010000, 1'b1},
      {8'h28, 8'h20, 24'h01ffff, 1'b0}, {8'h28, 8'h20, 24'h020000, 1'b1},
      {8'h38, 8'hd8, 24'h02ffff, 1'b0}, {8'h38, 8'hd8, 24'h030000, 1'b1},
      {8'h2c, 8'hc7, 24'h0, 1'b0}, {8'h00, 8'h60, 24'h0, 1'b1}};
    sfp_pkg::sfp_array_op_t e;
    for (int i = 0; i < 14; i++)
    begin
      wsr(t[i][40:33]);
      op(32'h06, 8);
      if (t[i][32:25] == 8'h02) e = sfp_pkg::SFP_ARRAY_PROGRAM;
      else if (t[i][32:25] == 8'h20) e = sfp_pkg::SFP_ARRAY_SECTOR;
      else if (t[i][32:25] == 8'hd8) e = sfp_pkg::SFP_ARRAY_BLOCK;
      else e = sfp_pkg::SFP_ARRAY_CHIP;
      if (e == sfp_pkg::SFP_ARRAY_CHIP) op({24'h0, t[i][32:25]}, 8);
      else op(t[i][32:1], 32);
      cmp("accept", t[i][0], gotV);
      if (t[i][0] && e != sfp_pkg::SFP_ARRAY_CHIP) cmp("req", {e, t[i][24:1]}, gotR);
    end
  endtask : s_protect
  task automatic s_abort;
    op(32'h06, 8);
    op(32'h0000003f, 13);
    cmp("abort", 8'h02, statusOut);
  endtask : s_abort
  // Status read, pause mid-read; deselect while paused must reset, then traffic resumes
  task automatic s_pause;
    logic [7:0] s = 8'h02;
    #3 host.chipSel_n = 1'b0;
    #7.5 host.shift(32'h05, 8);
    for (int i = 7; i >= 0; i--)
    begin
      #3 cmp("serout", s[i], serOut);
      cmp("drive", 1'b1, serOutEn);
      host.shift(32'h00, 1);
    end
    #3 host.pause_n = 1'b0;
    #1 cmp("hiz", 1'b0, serOutEn);
    host.shift(32'hff, 2);
    #3 cmp("hold", 1'b0, serOutEn);
    #4 host.chipSel_n = 1'b1;
    #20 host.pause_n = 1'b1;
    op(32'h04, 8);
    cmp("resume", 8'h00, statusOut);
  endtask : s_pause
  // Pause inside a status write: bits clocked while paused must not count
  task automatic s_hold;
    op(32'h06, 8);
    #3 host.chipSel_n = 1'b0;
    #7.5 host.shift(32'h018, 12);
    #3 host.pause_n = 1'b0;
    host.shift(32'h0f, 4);
    #3 host.pause_n = 1'b1;
    host.shift(32'h08, 4);
    #4 host.chipSel_n = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 cmp("heldwrite", 8'h88, statusOut);
    wsr(8'h00);
    cmp("heldclear", 8'h00, statusOut);
  endtask : s_hold
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    writeProtect_n = 1'b1;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge core_clk);
    s_status();
    s_protect();
    s_abort();
    s_pause();
    s_hold();
    report_and_stop();
  end
endmodule : tb_serial_flash_write_protect_hold
bind sfp_front sfp_front_sva chk (.core_clk(core_clk), .rst_n(rst_n), .sck(sck),
  .chipSel_n(chipSel_n), .pause_n(pause_n), .writeProtect_n(writeProtect_n),
  .serOutEn(serOutEn), .nvStore(nvStore), .arrayReqValid(arrayReqValid),
  .arrayReq(arrayReq), .statusOut(statusOut));
`default_nettype wire
